//--- logic/iesl_map.svh
// Register offsets, reset values and field positions of the interrupt enable/status block.
// Assumes inclusion by bare name from logic/ files only.
`ifndef IESL_MAP_SVH
`define IESL_MAP_SVH

// Byte offsets on the AXI4-Lite slave, one aligned word each
`define IESL_OFF_STATUS_LOW 4'h0
`define IESL_OFF_STATUS_MID 4'h4
`define IESL_OFF_ENABLE_LOW 4'h8
`define IESL_OFF_ENABLE_MID 4'hC
// Reset value of both enable registers
`define IESL_ENABLE_RST 16'hFFFF
// Unused source zero position
`define IESL_SRC0_BIT 0
// AXI response codes
`define IESL_RESP_OKAY 2'h0
`define IESL_RESP_SLVERR 2'h2

`endif

//--- logic/iesl_pkg.sv
// Types shared by the interrupt enable/status block.
// Assumes iesl_map.svh for numbers; holds types only.
package iesl_pkg;

    // Register selector decoded from a word address
    typedef enum logic [2:0] {
        IESL_SEL_STATUS_LOW,
        IESL_SEL_STATUS_MID,
        IESL_SEL_ENABLE_LOW,
        IESL_SEL_ENABLE_MID,
        IESL_SEL_NONE
    } iesl_sel_e;

    // Read answer carried as one bundle
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } iesl_rd_s;

    // Write request bundle after the address and data are both taken
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } iesl_wr_s;

endpackage : iesl_pkg

//--- logic/iesl_sync.sv
// Two-flop synchroniser for the 31 peripheral request levels.
// Assumes requests come from outside this clock's domain.
module iesl_sync (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:1] req_i,
    output logic [31:1] req_o
);
    logic [31:1] meta_r; // First stage, read only by second stage
    logic [31:1] hold_r; // Second stage

    // Two flops before any logic looks at the requests
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_r <= '0;
            hold_r <= '0;
        end else begin
            meta_r <= req_i;
            hold_r <= meta_r;
        end
    end

    assign req_o = hold_r;
endmodule : iesl_sync

//--- logic/iesl_mask.sv
// Enable gating of synchronised requests toward the priority encoder.
// Assumes enables and requests share one clock.
module iesl_mask (
    input wire logic [31:1] req_i,
    input wire logic [15:0] enable_low_i,
    input wire logic [15:0] enable_mid_i,
    output logic [31:0] masked_o
);
    logic [31:0] allow; // Combined enables, bit 0 forced off

    // Source zero has no request; its enable bit is ignored
    assign allow = {enable_mid_i, enable_low_i[15:1], 1'b0}; // [RULE3]
    // Only active and enabled sources pass; 0 blocks, 1 allows
    assign masked_o = {req_i, 1'b0} & allow; // [RULE5] [RULE12]
endmodule : iesl_mask

//--- logic/iesl_top.sv
// Interrupt enable masks and raw status for maskable sources 1..31, AXI4-Lite slave.
// Assumes level requests from peripherals and a priority encoder fed by masked_req_o.
//
// Overview of operation
// RULE1 - Low enable bits 15..1 gate sources 15..1
// RULE2 - Low enable resets to all ones
// RULE3 - Low enable bit 0 has no effect
// RULE4 - Mid enable bit n gates source n+16
// RULE5 - Enable 0 blocks, 1 allows
// RULE6 - Status registers read-only, ignore enables
// RULE7 - Low status bits 15..1 show requests
// RULE8 - Low status bit 0 reads zero
// RULE9 - Mid status bits show requests 31..16
// RULE10 - Status bit reads 1 while requesting
// RULE11 - Sources hold requests as levels
// RULE12 - Forward active enabled requests to encoder
// RULE13 - Enable writes next edge, status writes ignored
module iesl_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:1] irq_req_i,
    output logic [31:0] masked_req_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
`include "iesl_map.svh"

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [31:1] req_sync; // Requests after two flops
    logic [31:0] masked; // Gated requests, combinational
    logic [15:0] enable_low_r; // Source allow bits 15..0
    logic [15:0] enable_mid_r; // Source allow bits 31..16
    logic [15:0] status_low; // Raw active bits 15..0
    logic [15:0] status_mid; // Raw active bits 31..16
    logic aw_got_r; // Write address held
    logic w_got_r; // Write data held
    logic aw_bad_r; // Held write address lies outside the map
    iesl_pkg::iesl_wr_s wr_r; // Captured write request
    iesl_pkg::iesl_rd_s rd_nxt; // Read answer being formed
    logic wr_fire; // Both halves of a write present
    iesl_pkg::iesl_sel_e wr_sel; // Target of the write

    // Word address decode, shared by read and write paths
    function automatic iesl_pkg::iesl_sel_e decode_sel(input logic [31:0] addr);
        iesl_pkg::iesl_sel_e sel;
        sel = iesl_pkg::IESL_SEL_NONE;
        if (addr[31:4] == 28'h0000000) begin
            unique case ({addr[3:2], 2'b00})
                `IESL_OFF_STATUS_LOW: sel = iesl_pkg::IESL_SEL_STATUS_LOW;
                `IESL_OFF_STATUS_MID: sel = iesl_pkg::IESL_SEL_STATUS_MID;
                `IESL_OFF_ENABLE_LOW: sel = iesl_pkg::IESL_SEL_ENABLE_LOW;
                `IESL_OFF_ENABLE_MID: sel = iesl_pkg::IESL_SEL_ENABLE_MID;
            endcase
        end
        return sel;
    endfunction : decode_sel

    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] v;
        v = old_v;
        if (strb[0]) v[7:0] = d[7:0];
        if (strb[1]) v[15:8] = d[15:8];
        return v;
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////////////
    // Request path

    iesl_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .req_i(irq_req_i),
        .req_o(req_sync)
    );

    // Relies on sources holding levels until serviced; pulses shorter than one
    // clock may be missed by the synchroniser
    iesl_mask u_mask (
        .req_i(req_sync), // [RULE11]
        .enable_low_i(enable_low_r),
        .enable_mid_i(enable_mid_r),
        .masked_o(masked)
    );

    // Registered output toward the priority encoder
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            masked_req_o <= '0;
        end else begin
            masked_req_o <= masked; // [RULE12]
        end
    end

    // Raw status, independent of enables
    assign status_low = {req_sync[15:1], 1'b0}; // [RULE6] [RULE7] [RULE8] [RULE10]
    assign status_mid = req_sync[31:16]; // [RULE9] [RULE10]

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel

    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    // Only four address bits are kept, so an unmapped address needs its own flag
    assign wr_sel = aw_bad_r ? iesl_pkg::IESL_SEL_NONE : decode_sel({28'h0000000, wr_r.addr});

    // Address capture; ready only while no address held
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_got_r <= 1'b0;
            s_axi_awready <= 1'b1;
            wr_r.addr <= 4'h0;
            aw_bad_r <= 1'b0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            aw_got_r <= 1'b1;
            s_axi_awready <= 1'b0;
            wr_r.addr <= s_axi_awaddr[3:0];
            aw_bad_r <= (s_axi_awaddr[31:4] != 28'h0000000); // [RULE13]
        end else if (wr_fire) begin
            aw_got_r <= 1'b0;
        end else if (!aw_got_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Data capture; either order with the address
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w_got_r <= 1'b0;
            s_axi_wready <= 1'b1;
            wr_r.data <= 32'h00000000;
            wr_r.strb <= 4'h0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_got_r <= 1'b1;
            s_axi_wready <= 1'b0;
            wr_r.data <= s_axi_wdata;
            wr_r.strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_r <= 1'b0;
        end else if (!w_got_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Enable registers: reset to all ones, written the edge after both halves
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            enable_low_r <= `IESL_ENABLE_RST; // [RULE2]
            enable_mid_r <= `IESL_ENABLE_RST; // [RULE4]
        end else if (wr_fire) begin
            if (wr_sel == iesl_pkg::IESL_SEL_ENABLE_LOW) begin
                enable_low_r <= merge16(enable_low_r, wr_r.data, wr_r.strb); // [RULE1] [RULE13]
            end
            if (wr_sel == iesl_pkg::IESL_SEL_ENABLE_MID) begin
                enable_mid_r <= merge16(enable_mid_r, wr_r.data, wr_r.strb); // [RULE4] [RULE13]
            end
        end
    end

    // Write response; status writes are dropped with OKAY, unmapped gets SLVERR
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IESL_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == iesl_pkg::IESL_SEL_NONE) ? `IESL_RESP_SLVERR
                                                              : `IESL_RESP_OKAY; // [RULE13]
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel

    // Read mux; upper sixteen bits always zero
    always_comb begin
        rd_nxt.data = 32'h00000000;
        rd_nxt.resp = `IESL_RESP_OKAY;
        unique case (decode_sel(s_axi_araddr))
            iesl_pkg::IESL_SEL_STATUS_LOW: rd_nxt.data[15:0] = status_low; // [RULE6]
            iesl_pkg::IESL_SEL_STATUS_MID: rd_nxt.data[15:0] = status_mid; // [RULE6]
            iesl_pkg::IESL_SEL_ENABLE_LOW: rd_nxt.data[15:0] = enable_low_r;
            iesl_pkg::IESL_SEL_ENABLE_MID: rd_nxt.data[15:0] = enable_mid_r;
            iesl_pkg::IESL_SEL_NONE: rd_nxt.resp = `IESL_RESP_SLVERR;
        endcase
    end

    // One read in flight; arready drops while the answer waits
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IESL_RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt.data;
            s_axi_rresp <= rd_nxt.resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : iesl_top

//--- dv/iesl_chk_props.sv
// Checker: masking, status view and read answers of iesl_top.
// Assumes a bind from the bench top; sees top ports only.
module iesl_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:1] irq_req_i,
    input wire logic [31:0] masked_req_o,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [1:0] age_r; // Edges since reset; pipe is full at 3
    logic nowr_r; // No write yet, so enables hold reset value
    logic ar_w; // Read address taken
    assign ar_w = s_axi_arvalid && s_axi_arready;
    ////////////////////////////////////////
    // Age counter, saturating so $past depth 3 never sees reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    // Cleared by the first write address handshake
    always_ff @(posedge clk_i) begin
        nowr_r <= sys_rst_i ? 1'b1 : nowr_r && !(s_axi_awvalid && s_axi_awready);
    end
    ////////////////////////////////////////
    a_src0_quiet: assert property (masked_req_o[0] == 1'b0)
        else $error("masked bit 0 set");
    a_mask_track: assert property (age_r == 2'h3 && nowr_r |->
        masked_req_o[31:1] == $past(irq_req_i, 3)) else $error("masked requests wrong");
    a_status_low: assert property (ar_w && s_axi_araddr == 32'h0 && age_r == 2'h3 |=>
        s_axi_rdata[15:0] == {$past(irq_req_i[15:1], 3), 1'b0}) else $error("low status wrong");
    a_status_mid: assert property (ar_w && s_axi_araddr == 32'h4 && age_r == 2'h3 |=>
        s_axi_rdata[15:0] == $past(irq_req_i[31:16], 3)) else $error("mid status wrong");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_rd_unmapped: assert property (ar_w && s_axi_araddr[31:4] != 28'h0 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_rd_answer: assert property (ar_w |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : iesl_chk

//--- dv/iesl_src_model.sv
// Peripheral request sources as seen by the block.
// Assumes the bench picks each level; held until changed.
module iesl_src_model (
    input wire logic clk_i,
    input wire logic [31:1] lvl_i,
    output logic [31:1] irq_o = '0
);
    // Levels, never pulses: held until the bench changes them
    always @(posedge clk_i) irq_o <= lvl_i;
endmodule : iesl_src_model

//--- dv/testbench.sv
// Bench: drives AXI4-Lite and request levels, checks reads and masking.
// Assumes iesl_top, checker and source model compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, mp = 1'b0;
    logic [31:1] lvl = '0, irq_req_i;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [31:0] masked_req_o, s_axi_rdata, seed = 32'h61BFD9FF, r, e0, e1;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [33:0] rq[$]; // Expected {rdata, rresp}
    logic [1:0] bq[$]; // Expected bresp
    logic [31:0] mq[$]; // Expected masked vector
    int err_total = 0, comparisons = 0;
    iesl_src_model u_src (.clk_i, .lvl_i(lvl), .irq_o(irq_req_i));
    iesl_top u_dut (.clk_i, .sys_rst_i, .irq_req_i, .masked_req_o, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    initial forever #10 clk_i = ~clk_i;
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // Bounded wait ran out: count it and stop
    task automatic tmo(input int n);
        if (n >= 40) begin
            err_total++;
            tally_and_finish();
        end
    endtask : tmo
    // Leading edge keeps bready from two writes in one step
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge clk_i);
        bq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        tmo(n);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        int n;
        n = 0;
        @(posedge clk_i);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        tmo(n);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic mchk(input logic [31:0] e);
        mq.push_back(e);
        mp <= 1'b1;
        @(posedge clk_i);
        mp <= 1'b0;
    endtask : mchk
    ////////////////////////////////////////
    // Monitor: oldest note against each result as it appears
    always @(posedge clk_i) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rdata, s_axi_rresp}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (mp) chk({2'h0, masked_req_o}, {2'h0, mq.pop_front()});
    end
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(32'h8, {32'h0000FFFF, 2'h0});
        rd(32'hC, {32'h0000FFFF, 2'h0});
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            r = seed;
            lvl <= r[31:1];
            seed = lfsr(seed);
            e0 = seed & 32'hFFFF;
            seed = lfsr(seed);
            e1 = seed & 32'hFFFF;
            repeat (4) @(posedge clk_i);
            rd(32'h0, {16'h0, r[15:1], 1'b0, 2'h0});
            rd(32'h4, {16'h0, r[31:16], 2'h0});
            wr(32'h8, e0, 4'hF, 2'h0);
            wr(32'hC, e1, 4'hF, 2'h0);
            wr(32'h0, 32'h0, 4'hF, 2'h0);
            repeat (3) @(posedge clk_i);
            mchk({r[31:16] & e1[15:0], r[15:1] & e0[15:1], 1'b0});
            rd(32'h8, {e0, 2'h0});
            rd(32'h0, {16'h0, r[15:1], 1'b0, 2'h0});
        end
        rd(32'h10, {32'h0, 2'h2});
        wr(32'h10, 32'h0, 4'hF, 2'h2);
        wr(32'h8, 32'h0, 4'h1, 2'h0);
        rd(32'h8, {16'h0, e0[15:8], 8'h00, 2'h0});
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(32'h8, {32'h0000FFFF, 2'h0});
        tally_and_finish();
    end
endmodule : testbench
bind iesl_top iesl_chk u_chk (.clk_i, .sys_rst_i, .irq_req_i, .masked_req_o, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .s_axi_awvalid, .s_axi_awready);
